// [hw/status_regs.svh]
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH
// ************************
// register offsets
// ************************
`define OFF_STB      8'h00
`define OFF_SRE      8'h04
`define OFF_QCOND    8'h08
`define OFF_QEV      8'h0c
`define OFF_QEN      8'h10
`define OFF_ESR      8'h14
`define OFF_ESE      8'h18
`define OFF_ACOND    8'h1c
`define OFF_AEV      8'h20
`define OFF_AEN      8'h24
`define OFF_OCOND    8'h28
`define OFF_OEV      8'h2c
`define OFF_OEN      8'h30
`define OFF_AQUEUE   8'h34
`define OFF_THR      8'h38
`define OFF_CTL      8'h3c
`define OFF_PSC      8'h40
// ************************
// field positions
// ************************
`define CTL_CLS      0
`define CTL_PRESET   1
`define CTL_RST      2
`define CTL_OPC      3
`define STB_ALM      1
`define STB_ERRQ     2
`define STB_QUES     3
`define STB_MAV      4
`define STB_ESB      5
`define STB_MSS      6
`define STB_OPER     7
`define ESR_OPC      0
`define ESR_USED     8'hbf
`define ALM_QNE      4
`define ALM_OVF      5
`define OPER_SCAN    4
`define OPER_CFG     8
`define OPER_THR     9
`define AQ_VALID     16
// ************************
// reset values and limits
// ************************
`define W16_RST      16'h0000
`define B8_RST       8'h00
`define THR_MIN      16'h0001
`define THR_MAX      16'hc350
`define THR_RST      16'h0001
`define ALQ_DEPTH    16
`define ALQ_AW       4
`endif

// [hw/status_pkg.sv]
package status_pkg;
  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN  = 1'b1
  } init_t;
  typedef logic [15:0] word16_t;
  typedef logic [7:0]  byte8_t;
endpackage : status_pkg

// [hw/alarm_queue.sv]
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"
module alarm_queue (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // control
  input  wire logic               clear,
  input  wire logic               push,
  input  wire status_pkg::word16_t din,
  input  wire logic               pop,
  // state
  output status_pkg::word16_t     dout,
  output logic                    nempty,
  output logic                    overflow
);
  status_pkg::word16_t mem [`ALQ_DEPTH];
  logic [`ALQ_AW-1:0] wr_ptr_r;
  logic [`ALQ_AW-1:0] rd_ptr_r;
  logic [`ALQ_AW:0]   cnt_r;
  logic               full;
  logic               do_push;
  logic               do_pop;

  assign full    = (cnt_r == (`ALQ_AW+1)'(`ALQ_DEPTH));
  assign do_pop  = pop && (cnt_r != '0);
  // a full queue drops the newest record and flags the loss
  assign do_push = push && (!full || do_pop);
  // empty queue reads zero, never a stale or unwritten record
  assign dout    = (cnt_r != '0) ? mem[rd_ptr_r] : '0;
  assign nempty  = (cnt_r != '0);

  always_ff @(posedge hclk) begin
    if (do_push && !clear) begin
      mem[wr_ptr_r] <= din;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      overflow <= 1'b0;
    end else if (clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= push && full && !do_pop;
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + {{`ALQ_AW{1'b0}}, do_push}
                     - {{`ALQ_AW{1'b0}}, do_pop};
    end
  end
endmodule : alarm_queue
`default_nettype wire

// [hw/status_regs_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"
module status_regs_top (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // instrument events
  input  wire status_pkg::word16_t ques_set,
  input  wire status_pkg::word16_t ques_clr,
  input  wire status_pkg::byte8_t  std_event,
  input  wire logic               err_queue_nempty,
  input  wire logic               msg_avail,
  input  wire logic               serial_poll,
  input  wire logic               scanning,
  input  wire logic               scan_start,
  input  wire logic               config_change,
  input  wire status_pkg::word16_t reading_count,
  input  wire logic [3:0]         alarm_hit,
  input  wire status_pkg::word16_t alarm_rec,
  // stored power-on settings
  input  wire logic               psc_saved,
  input  wire status_pkg::byte8_t  sre_saved,
  input  wire status_pkg::byte8_t  ese_saved,
  // outputs to instrument
  output logic                    srq,
  output logic                    err_queue_clear,
  output logic                    psc_state
);
  // ************************
  // state
  // ************************
  status_pkg::init_t   init_r;
  status_pkg::byte8_t  sre_r;
  status_pkg::byte8_t  ese_r;
  status_pkg::byte8_t  esr_r;
  status_pkg::byte8_t  stb_r;
  status_pkg::byte8_t  stb_nxt;
  status_pkg::word16_t ques_cond_r;
  status_pkg::word16_t ques_ev_r;
  status_pkg::word16_t ques_en_r;
  status_pkg::word16_t alm_ev_r;
  status_pkg::word16_t alm_en_r;
  status_pkg::word16_t oper_ev_r;
  status_pkg::word16_t oper_en_r;
  status_pkg::word16_t oper_prev_r;
  status_pkg::word16_t thr_r;
  logic                cfg_r;
  logic                alm_prev_r;
  logic                thr_armed_r;
  logic                opc_pend_r;
  logic                ap_wr_r;
  logic [7:0]          ap_addr_r;
  // ************************
  // derived
  // ************************
  status_pkg::word16_t alm_cond;
  status_pkg::word16_t oper_cond;
  status_pkg::word16_t q_dout;
  logic                q_nempty;
  logic                q_ovf;
  logic                ques_sum;
  logic                alm_sum;
  logic                oper_sum;
  logic                esb;
  logic                mss;
  logic                acc;
  logic                rd;
  logic                wr_ctl;
  logic                do_cls;
  logic                do_preset;
  logic                do_rst;
  logic                do_opc;
  logic                opc_done;
  logic                thr_hit;
  logic                init;
  logic [31:0]         rd_val;

  // ************************
  // bus decode
  // ************************
  // only whole-word transfers are honoured; others complete as no-ops
  assign acc = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign rd  = acc && !hwrite;
  assign wr_ctl    = ap_wr_r && (ap_addr_r == `OFF_CTL);
  assign do_cls    = wr_ctl && hwdata[`CTL_CLS];
  assign do_preset = wr_ctl && hwdata[`CTL_PRESET];
  assign do_rst    = wr_ctl && hwdata[`CTL_RST];
  assign do_opc    = wr_ctl && hwdata[`CTL_OPC];
  assign init      = (init_r == status_pkg::ST_INIT);

  function automatic logic wr_at(input logic [7:0] off);
    wr_at = ap_wr_r && (ap_addr_r == off);
  endfunction : wr_at

  function automatic logic rd_at(input logic [7:0] off);
    rd_at = rd && (haddr[7:0] == off);
  endfunction : rd_at

  // ************************
  // group summaries
  // ************************
  assign alm_cond  = {11'h000, q_nempty, 4'h0};
  assign oper_cond = {6'h00, 1'b0, cfg_r, 3'h0, scanning, 4'h0};
  assign ques_sum  = |(ques_ev_r & ques_en_r);
  assign alm_sum   = |(alm_ev_r & alm_en_r);
  assign oper_sum  = |(oper_ev_r & oper_en_r);
  assign esb       = |(esr_r & ese_r);

  always_comb begin
    stb_nxt = `B8_RST;
    stb_nxt[`STB_ALM]  = alm_sum;
    stb_nxt[`STB_ERRQ] = err_queue_nempty;
    stb_nxt[`STB_QUES] = ques_sum;
    stb_nxt[`STB_MAV]  = msg_avail;
    stb_nxt[`STB_ESB]  = esb;
    stb_nxt[`STB_OPER] = oper_sum;
    mss = |(stb_nxt & sre_r);
    stb_nxt[`STB_MSS]  = mss;
  end

  // ************************
  // read mux
  // ************************
  always_comb begin
    case (haddr[7:0])
      `OFF_STB:    rd_val = {24'h000000, stb_r};
      `OFF_SRE:    rd_val = {24'h000000, sre_r};
      `OFF_QCOND:  rd_val = {16'h0000, ques_cond_r};
      `OFF_QEV:    rd_val = {16'h0000, ques_ev_r};
      `OFF_QEN:    rd_val = {16'h0000, ques_en_r};
      `OFF_ESR:    rd_val = {24'h000000, esr_r};
      `OFF_ESE:    rd_val = {24'h000000, ese_r};
      `OFF_ACOND:  rd_val = {16'h0000, alm_cond};
      `OFF_AEV:    rd_val = {16'h0000, alm_ev_r};
      `OFF_AEN:    rd_val = {16'h0000, alm_en_r};
      `OFF_OCOND:  rd_val = {16'h0000, oper_cond};
      `OFF_OEV:    rd_val = {16'h0000, oper_ev_r};
      `OFF_OEN:    rd_val = {16'h0000, oper_en_r};
      `OFF_AQUEUE: rd_val = {15'h0000, q_nempty, q_dout};
      `OFF_THR:    rd_val = {16'h0000, thr_r};
      `OFF_CTL:    rd_val = {28'h0000000, opc_pend_r, 3'h0};
      `OFF_PSC:    rd_val = {31'h00000000, psc_state};
      default:     rd_val = 32'h00000000;
    endcase
  end

  // ************************
  // ahb-lite slave
  // ************************
  // zero wait: read side effects fire at the address-phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_wr_r   <= acc && hwrite;
      ap_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd) begin
        hrdata <= rd_val;
      end
    end
  end

  // ************************
  // power-up and summary
  // ************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_r    <= status_pkg::ST_INIT;
      psc_state <= 1'b0;
    end else begin
      init_r <= status_pkg::ST_RUN;
      if (init) begin
        psc_state <= psc_saved;
      end else if (wr_at(`OFF_PSC)) begin
        psc_state <= hwdata[0];
      end
    end
  end

  // summary condition starts cleared, so it is rebuilt from live state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stb_r <= `B8_RST;
      srq   <= 1'b0;
    end else begin
      stb_r <= stb_nxt;
      // serial poll drops the request, never the summary bit
      srq <= (mss && !stb_r[`STB_MSS]) || (srq && !serial_poll);
    end
  end

  // ************************
  // enables
  // ************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sre_r <= `B8_RST;
      ese_r <= `B8_RST;
    end else if (init) begin
      if (!psc_saved) begin
        sre_r <= sre_saved;
        ese_r <= ese_saved;
      end
    end else begin
      if (wr_at(`OFF_SRE)) begin
        sre_r <= hwdata[7:0];
      end
      if (wr_at(`OFF_ESE)) begin
        ese_r <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ques_en_r <= `W16_RST;
      alm_en_r  <= `W16_RST;
      oper_en_r <= `W16_RST;
    end else if (do_preset) begin
      ques_en_r <= `W16_RST;
      alm_en_r  <= `W16_RST;
      oper_en_r <= `W16_RST;
    end else begin
      if (wr_at(`OFF_QEN)) begin
        ques_en_r <= hwdata[15:0];
      end
      if (wr_at(`OFF_AEN)) begin
        alm_en_r <= hwdata[15:0];
      end
      if (wr_at(`OFF_OEN)) begin
        oper_en_r <= hwdata[15:0];
      end
    end
  end

  // ************************
  // questionable group
  // ************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ques_cond_r <= `W16_RST;
      ques_ev_r   <= `W16_RST;
    end else begin
      ques_cond_r <= do_rst ? `W16_RST
                            : ((ques_cond_r & ~ques_clr) | ques_set);
      // set wins over the query or clear landing in the same cycle
      ques_ev_r <= (ques_ev_r & ~{16{rd_at(`OFF_QEV) || do_cls}})
                 | (ques_set & ~ques_cond_r);
    end
  end

  // ************************
  // standard event group
  // ************************
  assign opc_done = opc_pend_r && !scanning;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      esr_r      <= `B8_RST;
      opc_pend_r <= 1'b0;
    end else begin
      // a query leaves this register alone; only the clear action empties it
      esr_r <= ((esr_r & ~{8{do_cls}}) | (std_event & `ESR_USED)
               | {7'h00, opc_done});
      opc_pend_r <= do_opc || (opc_pend_r && scanning);
    end
  end

  // ************************
  // alarm group
  // ************************
  alarm_queue u_alarm_queue (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (do_cls || do_rst),
    .push     (|alarm_hit),
    .din      (alarm_rec),
    .pop      (rd_at(`OFF_AQUEUE)),
    .dout     (q_dout),
    .nempty   (q_nempty),
    .overflow (q_ovf)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alm_ev_r   <= `W16_RST;
      alm_prev_r <= 1'b0;
    end else begin
      alm_prev_r <= q_nempty;
      alm_ev_r <= (alm_ev_r & ~{16{rd_at(`OFF_AEV) || do_cls}})
                | {10'h000, q_ovf, q_nempty && !alm_prev_r,
                   alarm_hit};
    end
  end

  // ************************
  // operation group
  // ************************
  assign thr_hit = scanning && thr_armed_r
                && (reading_count >= thr_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r       <= 1'b0;
      oper_prev_r <= `W16_RST;
      oper_ev_r   <= `W16_RST;
    end else begin
      cfg_r <= do_rst || config_change || (cfg_r && !scan_start);
      oper_prev_r <= oper_cond;
      oper_ev_r <= (oper_ev_r & ~{16{rd_at(`OFF_OEV) || do_cls}})
                 | (oper_cond & ~oper_prev_r)
                 | {6'h00, thr_hit, 9'h000};
    end
  end

  // the count must dip below the threshold before another event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_r       <= `THR_RST;
      thr_armed_r <= 1'b1;
    end else begin
      if (wr_at(`OFF_THR) && (hwdata[31:16] == 16'h0000)
          && (hwdata[15:0] >= `THR_MIN)
          && (hwdata[15:0] <= `THR_MAX)) begin
        thr_r <= hwdata[15:0];
      end
      if (reading_count < thr_r) begin
        thr_armed_r <= 1'b1;
      end else if (thr_hit) begin
        thr_armed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_queue_clear <= 1'b0;
    end else begin
      err_queue_clear <= do_cls;
    end
  end

  // ************************
  // checks
  // ************************
  stb_mss_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    serial_poll && mss |=> stb_r[`STB_MSS])
    else $error("summary bit lost on serial poll");

  sre_survives_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (do_cls || do_preset) && !init |=> sre_r == $past(sre_r))
    else $error("summary enable changed by clear or preset");

  ques_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_at(`OFF_QEV) && !do_cls
    |=> (ques_ev_r & $past(ques_ev_r)) == $past(ques_ev_r))
    else $error("questionable event bit dropped");

  esr_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !do_cls |=> (esr_r & $past(esr_r)) == $past(esr_r))
    else $error("standard event bit dropped");

  preset_en_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    do_preset |=> ques_en_r == 16'h0000 && alm_en_r == 16'h0000
      && oper_en_r == 16'h0000 && ese_r == $past(ese_r))
    else $error("preset enable handling wrong");

  cls_queue_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    do_cls ##1 !(|alarm_hit) |-> !q_nempty && err_queue_clear)
    else $error("clear left a queue untouched");

  alm_cond_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_at(`OFF_ACOND)
    |=> hrdata == ($past(q_nempty) ? 32'h00000010 : 32'h00000000))
    else $error("alarm condition reads stray bits");

  thr_event_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    thr_hit |=> oper_ev_r[`OPER_THR] && !thr_armed_r)
    else $error("threshold event not raised");

  thr_rearm_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !thr_armed_r && (reading_count >= thr_r) |=> !thr_armed_r)
    else $error("threshold rearmed too early");

  opc_done_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    scanning && !esr_r[`ESR_OPC] && !std_event[`ESR_OPC]
    |=> !esr_r[`ESR_OPC])
    else $error("operation complete before scan end");

  opc_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    opc_pend_r && !scanning && !do_opc
    |=> esr_r[`ESR_OPC] && !opc_pend_r)
    else $error("operation complete bit not set");
endmodule : status_regs_top
`default_nettype wire

// [sim/scan_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_model (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // control from bench
  input  wire logic                go,
  input  wire logic                clr,
  input  wire status_pkg::word16_t target,
  // scan state
  output logic                     scanning,
  output status_pkg::word16_t      reading_count
);
  // ************************
  // scan engine
  // ************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scanning <= 1'b0;
    end else if (go) begin
      scanning <= 1'b1;
    end else if (scanning && reading_count == target) begin
      scanning <= 1'b0;
    end
  end
  // stored count held after a scan, so a rerun starts from it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reading_count <= 16'h0000;
    end else if (clr) begin
      reading_count <= 16'h0000;
    end else if (scanning && reading_count != target) begin
      reading_count <= reading_count + 16'h0001;
    end
  end
endmodule : scan_model
`default_nettype wire

// [sim/status_regs_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module status_regs_top_tb;
  // ************************
  // signals
  // ************************
  logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                hready;
  status_pkg::word16_t ques_set, reading_count, alarm_rec, target;
  status_pkg::byte8_t  std_event, sre_saved, ese_saved;
  logic                serial_poll, scanning, config_change, psc_saved;
  logic [3:0]          alarm_hit;
  logic                srq, err_queue_clear, psc_state, go, clr;
  int                  fail_count, checked;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  status_regs_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ques_set,
    .ques_clr(16'h0000), .std_event, .err_queue_nempty(1'b0),
    .msg_avail(1'b0), .serial_poll, .scanning, .scan_start(1'b0),
    .config_change, .reading_count, .alarm_hit, .alarm_rec, .psc_saved,
    .sre_saved, .ese_saved, .srq, .err_queue_clear, .psc_state);
  scan_model u_scan (.hclk, .hresetn, .go, .clr, .target, .scanning,
    .reading_count);
  // ************************
  // tasks
  // ************************
  task results;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  // master holds each phase until hready, so no wait count is assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= {24'h000000, a}; hwrite <= w; htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    htrans <= 2'b00; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    r = hrdata;
    if (n >= 64) begin fail_count++; results(); end
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(nm, r, e);
  endtask : rd
  task start(input logic [15:0] t);
    target <= t; go <= 1'b1; tick(1); go <= 1'b0; tick(1);
  endtask : start
  task finish_scan;
    int n;
    n = 0;
    while (scanning !== 1'b0 && n < 200) begin tick(1); n++; end
    if (n >= 200) begin fail_count++; results(); end
    tick(2);
  endtask : finish_scan
  task do_reset(input logic p);
    psc_saved <= p; hresetn <= 1'b0; tick(6); hresetn <= 1'b1; tick(2);
  endtask : do_reset
  task push(input logic [3:0] h, input logic [15:0] rec);
    alarm_hit <= h; alarm_rec <= rec; tick(1); alarm_hit <= 4'h0; tick(1);
  endtask : push
  // ************************
  // main sequence
  // ************************
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ques_set = 16'h0000;
    std_event = 8'h00; serial_poll = 1'b0; config_change = 1'b0;
    alarm_hit = 4'h0; alarm_rec = 16'h0000; psc_saved = 1'b0; go = 1'b0;
    sre_saved = 8'h20; ese_saved = 8'h04; clr = 1'b0; target = 16'h0000;
    fail_count = 0; checked = 0;
    do_reset(1'b0);
    rd(8'h04, 32'h20, "sre kept");
    rd(8'h18, 32'h04, "ese kept");
    rd(8'h40, 32'h0, "psc");
    rd(8'h24, 32'h0, "aen pwr");
    rd(8'h30, 32'h0, "oen pwr");
    rd(8'h38, 32'h1, "thr dflt");
    wr(8'h10, 32'h8); wr(8'h24, 32'h3); wr(8'h30, 32'h200); wr(8'h04, 32'h8);
    rd(8'h30, 32'h200, "oen");
    wr(8'h3c, 32'h2);
    rd(8'h10, 32'h0, "qen preset");
    rd(8'h24, 32'h0, "aen preset");
    rd(8'h04, 32'h8, "sre preset");
    rd(8'h18, 32'h4, "ese preset");
    wr(8'h38, 32'h0); wr(8'h38, 32'hc351);
    rd(8'h38, 32'h1, "thr range");
    wr(8'h38, 32'hc350);
    rd(8'h38, 32'hc350, "thr max");
    wr(8'h38, 32'h3); wr(8'h10, 32'h8);
    ques_set <= 16'h0008; tick(1); ques_set <= 16'h0000; tick(3);
    rd(8'h08, 32'h8, "qcond");
    rd(8'h08, 32'h8, "qcond again");
    chk("srq", srq, 1'b1);
    rd(8'h00, 32'h48, "stb");
    serial_poll <= 1'b1; tick(1); serial_poll <= 1'b0; tick(2);
    chk("srq poll", srq, 1'b0);
    rd(8'h00, 32'h48, "stb mss");
    rd(8'h0c, 32'h8, "qev");
    rd(8'h0c, 32'h0, "qev clr");
    std_event <= 8'h04; tick(1); std_event <= 8'h00; tick(1);
    rd(8'h14, 32'h4, "esr");
    rd(8'h14, 32'h4, "esr sticky");
    wr(8'h3c, 32'h1);
    tick(1);
    chk("eq clr", err_queue_clear, 1'b1);
    tick(1);
    chk("eq clr end", err_queue_clear, 1'b0);
    rd(8'h14, 32'h0, "esr cls");
    rd(8'h18, 32'h4, "ese cls");
    rd(8'h10, 32'h8, "qen cls");
    push(4'h1, 16'h0aa1); push(4'h2, 16'h0bb2); tick(2);
    rd(8'h1c, 32'h10, "acond");
    rd(8'h20, 32'h13, "aev");
    rd(8'h20, 32'h0, "aev clr");
    rd(8'h34, 32'h10aa1, "queue 1");
    rd(8'h34, 32'h10bb2, "queue 2");
    rd(8'h34, 32'h0, "queue empty");
    rd(8'h1c, 32'h0, "acond empty");
    repeat (17) push(4'h1, 16'h0cc3);
    tick(2);
    rd(8'h20, 32'h31, "aev ovf");
    wr(8'h3c, 32'h1);
    rd(8'h34, 32'h0, "queue cls");
    rd(8'h20, 32'h0, "aev cls");
    start(16'h0005); finish_scan();
    rd(8'h2c, 32'h210, "thr event");
    rd(8'h2c, 32'h0, "oev clr");
    start(16'h0008); finish_scan();
    rd(8'h2c, 32'h10, "no rearm");
    clr <= 1'b1; tick(1); clr <= 1'b0;
    start(16'h0005); finish_scan();
    rd(8'h2c, 32'h210, "rearm");
    start(16'h0030);
    wr(8'h3c, 32'h8);
    rd(8'h14, 32'h0, "opc early");
    finish_scan();
    rd(8'h14, 32'h1, "opc done");
    wr(8'h3c, 32'h4);
    rd(8'h08, 32'h0, "qcond rst");
    rd(8'h28, 32'h100, "ocond cfg");
    rd(8'h28, 32'h100, "ocond held");
    hsize <= 3'h0;
    wr(8'h04, 32'hff);
    hsize <= 3'h2;
    rd(8'h04, 32'h8, "sre size");
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h1, "psc wr");
    chk("hresp", hresp, 1'b0);
    wr(8'h80, 32'h5);
    rd(8'h80, 32'h0, "unmapped");
    do_reset(1'b1);
    rd(8'h04, 32'h0, "sre psc1");
    rd(8'h18, 32'h0, "ese psc1");
    rd(8'h40, 32'h1, "psc1");
    results();
  end
endmodule : status_regs_top_tb
`default_nettype wire
